// ===== sstr_cfg.svh
// register map, field defaults and mode byte bit positions of the sequencer bank
`ifndef SSTR_CFG_SVH
`define SSTR_CFG_SVH

// ==========================================================
// byte addresses on the configuration port
`define SSTR_ADDR_MODE        7'h28
`define SSTR_ADDR_EXP_ONE     7'h29
`define SSTR_ADDR_EXP_TWO     7'h2c
`define SSTR_ADDR_SLOPES      7'h2f
`define SSTR_ADDR_KNEE_ONE    7'h30
`define SSTR_ADDR_KNEE_TWO    7'h33
`define SSTR_ADDR_FRAMES      7'h36
`define SSTR_ADDR_TRAIN       7'h38
`define SSTR_ADDR_BLANK       7'h3a
`define SSTR_ADDR_MUX         7'h3b
`define SSTR_ADDR_SHUTDOWN    7'h3c
`define SSTR_ADDR_SLOT        7'h3d
`define SSTR_ADDR_ROW         7'h3e
`define SSTR_ADDR_SAMPLE      7'h41

// ==========================================================
// reset values
`define SSTR_RST_MODE         8'h04
`define SSTR_RST_EXP_ONE      24'h0013c0
`define SSTR_RST_EXP_TWO      24'h000000
`define SSTR_RST_SLOPES       2'h1
`define SSTR_RST_KNEE_ONE     24'h000000
`define SSTR_RST_KNEE_TWO     24'h000000
`define SSTR_RST_FRAMES       16'h0001
`define SSTR_RST_TRAIN        12'h055
`define SSTR_RST_BLANK        8'h01
`define SSTR_RST_MUX          5'h01
`define SSTR_RST_SHUTDOWN     4'h7
`define SSTR_RST_SLOT         8'h70
`define SSTR_RST_ROW          7'h02
`define SSTR_RST_SAMPLE       8'h60

// ==========================================================
// field positions in the mode byte
`define SSTR_MODE_EXT_BIT     0
`define SSTR_MODE_DUAL_BIT    1

`endif

// ===== sstr_pkg.sv
// types shared by the sequencer timing bank
package sstr_pkg;

	// ==========================================================
	// configuration port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} sstr_req_t;

	// ==========================================================
	// settings as seen by the sequencer
	typedef struct packed {
		logic ext_mode;
		logic dual_mode;
		logic [23:0] exp_one;
		logic [23:0] exp_two;
		logic [1:0] slopes;
		logic [23:0] knee_one;
		logic [23:0] knee_two;
		logic [15:0] frames;
		logic [11:0] train_word;
		logic [7:0] blank_rows;
		logic [4:0] lane_mux;
		logic [3:0] lane_shutdown;
		logic [7:0] slot_cycles;
		logic [6:0] row_slots;
		logic [7:0] sample_len;
	} sstr_cfg_t;

	typedef enum logic [2:0] {
		SSTR_IDLE = 3'b001,
		SSTR_EXPOSE = 3'b010,
		SSTR_READ = 3'b100
	} sstr_state_t;

endpackage

// ===== sstr_byte_field.sv
// one multi-byte field, little-endian over consecutive byte addresses
`timescale 1ns/1ps
`include "sstr_cfg.svh"

module sstr_byte_field #(
	parameter int NBYTES = 3,
	parameter int WIDTH = 24,
	parameter logic [6:0] BASE = 7'h00,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	output logic [WIDTH-1:0] value,
	output logic hit,
	output logic [7:0] rbyte
);
	logic [NBYTES*8-1:0] val_r;
	logic [NBYTES*8-1:0] val_nxt;
	localparam logic [NBYTES*8-1:0] RST_FULL = (NBYTES*8)'(RESET_VAL);
	localparam logic [NBYTES*8-1:0] KEEP = (NBYTES*8)'({WIDTH{1'b1}});

	// ==========================================================
	// byte lanes, lowest address holds the least significant byte
	always_comb begin
		val_nxt = val_r;
		hit = 1'b0;
		rbyte = 8'h00;
		for (int i = 0; i < NBYTES; i++) begin
			if (addr == BASE + 7'(i)) begin
				hit = 1'b1;
				rbyte = val_r[i*8 +: 8];
				if (wr) begin
					val_nxt[i*8 +: 8] = wdata;
				end
			end
		end
		// unimplemented upper bits always read zero
		val_nxt = val_nxt & KEEP;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			val_r <= RST_FULL;
		end else begin
			val_r <= val_nxt;
		end
	end

	assign value = val_r[WIDTH-1:0];
endmodule // sstr_byte_field

// ===== sstr_frame_seq.sv
// frame burst counter that turns request pulses into exposure/readout frames
`timescale 1ns/1ps
`include "sstr_cfg.svh"

module sstr_frame_seq (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic frame_req,
	input wire logic ext_mode,
	input wire logic ext_exposure,
	input wire logic [15:0] frames,
	input wire logic [23:0] exp_len,
	input wire logic row_done,
	input wire logic [15:0] rows_per_frame,
	output sstr_pkg::sstr_state_t state,
	output logic frame_active,
	output logic [15:0] frames_left
);
	sstr_pkg::sstr_state_t state_r;
	sstr_pkg::sstr_state_t state_nxt;
	logic [15:0] left_r;
	logic [15:0] left_nxt;
	logic [23:0] cnt_r;
	logic [23:0] cnt_nxt;

	// ==========================================================
	// frame state
	always_comb begin
		state_nxt = state_r;
		left_nxt = left_r;
		cnt_nxt = cnt_r;
		case (state_r)
			sstr_pkg::SSTR_IDLE: begin
				cnt_nxt = 24'h000000;
				if (ext_mode && ext_exposure) begin
					// external mode ignores the burst count
					left_nxt = 16'h0001;
					state_nxt = sstr_pkg::SSTR_EXPOSE;
				end else if (!ext_mode && frame_req && frames != 16'h0000) begin
					left_nxt = frames;
					state_nxt = sstr_pkg::SSTR_EXPOSE;
				end
			end
			sstr_pkg::SSTR_EXPOSE: begin
				cnt_nxt = cnt_r + 24'h000001;
				if (ext_mode ? !ext_exposure : (cnt_r + 24'h000001 >= exp_len)) begin
					cnt_nxt = 24'h000000;
					state_nxt = sstr_pkg::SSTR_READ;
				end
			end
			sstr_pkg::SSTR_READ: begin
				if (row_done) begin
					cnt_nxt = cnt_r + 24'h000001;
					if (cnt_r[15:0] + 16'h0001 >= rows_per_frame) begin
						cnt_nxt = 24'h000000;
						left_nxt = left_r - 16'h0001;
						state_nxt = (left_r == 16'h0001) ?
							sstr_pkg::SSTR_IDLE : sstr_pkg::SSTR_EXPOSE;
					end
				end
			end
			default: state_nxt = sstr_pkg::SSTR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= sstr_pkg::SSTR_IDLE;
			left_r <= 16'h0000;
			cnt_r <= 24'h000000;
		end else begin
			state_r <= state_nxt;
			left_r <= left_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign state = state_r;
	assign frame_active = (state_r != sstr_pkg::SSTR_IDLE);
	assign frames_left = left_r;
endmodule // sstr_frame_seq

// ===== sstr_timing_regs.sv
// sequencer timing register bank with the slot/row/sample timing it steers
// ==========================================================
`timescale 1ns/1ps
`include "sstr_cfg.svh"

module sstr_timing_regs #(
	parameter int ROWS_PER_FRAME = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [6:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	input wire logic frame_req,
	input wire logic ext_exposure,
	output sstr_pkg::sstr_cfg_t cfg,
	output logic frame_active,
	output logic data_valid_slot,
	output logic row_start,
	output logic sample_pulse,
	output logic odd_row,
	output logic [23:0] row_exposure,
	output logic [11:0] train_word,
	output logic [4:0] lane_mux,
	output logic [3:0] lane_shutdown
);
	sstr_pkg::sstr_req_t req;
	sstr_pkg::sstr_state_t seq_state;

	logic [7:0] mode_r;
	logic [7:0] mode_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	localparam int NF = 13;
	logic [NF-1:0] hit;
	logic [7:0] rb [NF];

	logic [23:0] v_exp_one;
	logic [23:0] exposure_time_group_two;
	logic [1:0] v_slopes;
	logic [23:0] knee_one_time;
	logic [23:0] knee_two_time;
	logic [15:0] v_frames;
	logic [11:0] v_train;
	logic [7:0] v_blank;
	logic [4:0] v_mux;
	logic [3:0] v_shut;
	logic [7:0] v_slot;
	logic [6:0] v_row;
	logic [7:0] v_sample;

	assign req = '{wr: cfg_wr, rd: cfg_rd, addr: cfg_addr, wdata: cfg_wdata};

	// ==========================================================
	// field storage
	// a wide field changes one byte per write, so the sequencer can see a
	// half-written value in between; the host writes every byte before it
	// requests a frame
	sstr_byte_field #(.NBYTES(3), .WIDTH(24), .BASE(`SSTR_ADDR_EXP_ONE),
		.RESET_VAL(`SSTR_RST_EXP_ONE)) u_exp_one (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_exp_one),
		.hit(hit[0]), .rbyte(rb[0]));
	sstr_byte_field #(.NBYTES(3), .WIDTH(24), .BASE(`SSTR_ADDR_EXP_TWO),
		.RESET_VAL(`SSTR_RST_EXP_TWO)) u_exp_two (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata),
		.value(exposure_time_group_two), .hit(hit[1]), .rbyte(rb[1]));
	sstr_byte_field #(.NBYTES(1), .WIDTH(2), .BASE(`SSTR_ADDR_SLOPES),
		.RESET_VAL(`SSTR_RST_SLOPES)) u_slopes (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_slopes),
		.hit(hit[2]), .rbyte(rb[2]));
	sstr_byte_field #(.NBYTES(3), .WIDTH(24), .BASE(`SSTR_ADDR_KNEE_ONE),
		.RESET_VAL(`SSTR_RST_KNEE_ONE)) u_knee_one (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata),
		.value(knee_one_time), .hit(hit[3]), .rbyte(rb[3]));
	sstr_byte_field #(.NBYTES(3), .WIDTH(24), .BASE(`SSTR_ADDR_KNEE_TWO),
		.RESET_VAL(`SSTR_RST_KNEE_TWO)) u_knee_two (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata),
		.value(knee_two_time), .hit(hit[4]), .rbyte(rb[4]));
	sstr_byte_field #(.NBYTES(2), .WIDTH(16), .BASE(`SSTR_ADDR_FRAMES),
		.RESET_VAL(`SSTR_RST_FRAMES)) u_frames (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_frames),
		.hit(hit[5]), .rbyte(rb[5]));
	sstr_byte_field #(.NBYTES(2), .WIDTH(12), .BASE(`SSTR_ADDR_TRAIN),
		.RESET_VAL(`SSTR_RST_TRAIN)) u_train (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_train),
		.hit(hit[6]), .rbyte(rb[6]));
	sstr_byte_field #(.NBYTES(1), .WIDTH(8), .BASE(`SSTR_ADDR_BLANK),
		.RESET_VAL(`SSTR_RST_BLANK)) u_blank (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_blank),
		.hit(hit[7]), .rbyte(rb[7]));
	sstr_byte_field #(.NBYTES(1), .WIDTH(5), .BASE(`SSTR_ADDR_MUX),
		.RESET_VAL(`SSTR_RST_MUX)) u_mux (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_mux),
		.hit(hit[8]), .rbyte(rb[8]));
	sstr_byte_field #(.NBYTES(1), .WIDTH(4), .BASE(`SSTR_ADDR_SHUTDOWN),
		.RESET_VAL(`SSTR_RST_SHUTDOWN)) u_shut (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_shut),
		.hit(hit[9]), .rbyte(rb[9]));
	sstr_byte_field #(.NBYTES(1), .WIDTH(8), .BASE(`SSTR_ADDR_SLOT),
		.RESET_VAL(`SSTR_RST_SLOT)) u_slot (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_slot),
		.hit(hit[10]), .rbyte(rb[10]));
	sstr_byte_field #(.NBYTES(1), .WIDTH(7), .BASE(`SSTR_ADDR_ROW),
		.RESET_VAL(`SSTR_RST_ROW)) u_row (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_row),
		.hit(hit[11]), .rbyte(rb[11]));
	sstr_byte_field #(.NBYTES(1), .WIDTH(8), .BASE(`SSTR_ADDR_SAMPLE),
		.RESET_VAL(`SSTR_RST_SAMPLE)) u_sample (.clk(clk), .rst_b(rst_b),
		.wr(req.wr), .addr(req.addr), .wdata(req.wdata), .value(v_sample),
		.hit(hit[12]), .rbyte(rb[12]));

	// ==========================================================
	// exposure mode byte and read data register
	// the sync bit of the mode byte is stored for read-back only and steers
	// nothing in this block; read data is registered and holds until the
	// next read, so the host may pick it up any time after its request
	always_comb begin
		mode_nxt = mode_r;
		if (req.wr && req.addr == `SSTR_ADDR_MODE) begin
			mode_nxt = req.wdata;
		end
		rdata_nxt = rdata_r;
		if (req.rd) begin
			// unmapped addresses read zero
			rdata_nxt = (req.addr == `SSTR_ADDR_MODE) ? mode_r : 8'h00;
			for (int i = 0; i < NF; i++) begin
				if (hit[i]) begin
					rdata_nxt = rb[i];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= `SSTR_RST_MODE;
			rdata_r <= 8'h00;
		end else begin
			mode_r <= mode_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign cfg_rdata = rdata_r;

	always_comb begin
		cfg.ext_mode = mode_r[`SSTR_MODE_EXT_BIT];
		cfg.dual_mode = mode_r[`SSTR_MODE_DUAL_BIT];
		cfg.exp_one = v_exp_one;
		cfg.exp_two = exposure_time_group_two;
		cfg.slopes = v_slopes;
		cfg.knee_one = knee_one_time;
		cfg.knee_two = knee_two_time;
		cfg.frames = v_frames;
		cfg.train_word = v_train;
		cfg.blank_rows = v_blank;
		cfg.lane_mux = v_mux;
		cfg.lane_shutdown = v_shut;
		cfg.slot_cycles = v_slot;
		cfg.row_slots = v_row;
		cfg.sample_len = v_sample;
	end

	assign train_word = v_train;
	assign lane_mux = v_mux;
	assign lane_shutdown = v_shut;

	// ==========================================================
	// slot, row and sampling timing
	// the slot and row sums below are eight and seven bits wide: a slot or
	// row length of zero behaves like one
	// a sampling length longer than the row keeps the pulse high from one
	// row to the next, since the pulse counter restarts with every row
	logic [7:0] slot_cnt_r;
	logic [7:0] slot_cnt_nxt;
	logic [6:0] slot_idx_r;
	logic [6:0] slot_idx_nxt;
	logic [7:0] smp_cnt_r;
	logic [7:0] smp_cnt_nxt;
	logic [15:0] row_cnt_r;
	logic [15:0] row_cnt_nxt;
	logic data_valid_slot_r;
	logic data_valid_slot_nxt;
	logic rstart_r;
	logic rstart_nxt;
	logic smp_r;
	logic smp_nxt;
	logic row_done;
	logic reading;
	logic [15:0] rows_total;

	assign reading = (seq_state == sstr_pkg::SSTR_READ);
	// blank rows ride along with the image rows of every frame
	assign rows_total = 16'(ROWS_PER_FRAME) + {8'h00, v_blank};
	assign row_done = reading && (slot_cnt_r + 8'h01 >= v_slot) &&
		(slot_idx_r + 7'h01 >= v_row);

	always_comb begin
		slot_cnt_nxt = 8'h00;
		slot_idx_nxt = 7'h00;
		smp_cnt_nxt = 8'h00;
		data_valid_slot_nxt = 1'b0;
		rstart_nxt = 1'b0;
		smp_nxt = 1'b0;
		if (reading) begin
			data_valid_slot_nxt = 1'b1;
			slot_cnt_nxt = slot_cnt_r + 8'h01;
			slot_idx_nxt = slot_idx_r;
			smp_cnt_nxt = (smp_cnt_r < v_sample) ? smp_cnt_r + 8'h01 : smp_cnt_r;
			smp_nxt = (smp_cnt_r < v_sample);
			rstart_nxt = (slot_cnt_r == 8'h00) && (slot_idx_r == 7'h00);
			if (slot_cnt_r + 8'h01 >= v_slot) begin
				slot_cnt_nxt = 8'h00;
				slot_idx_nxt = slot_idx_r + 7'h01;
				if (slot_idx_r + 7'h01 >= v_row) begin
					slot_idx_nxt = 7'h00;
					smp_cnt_nxt = 8'h00;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_cnt_r <= 8'h00;
			slot_idx_r <= 7'h00;
			smp_cnt_r <= 8'h00;
			data_valid_slot_r <= 1'b0;
			rstart_r <= 1'b0;
			smp_r <= 1'b0;
		end else begin
			slot_cnt_r <= slot_cnt_nxt;
			slot_idx_r <= slot_idx_nxt;
			smp_cnt_r <= smp_cnt_nxt;
			data_valid_slot_r <= data_valid_slot_nxt;
			rstart_r <= rstart_nxt;
			smp_r <= smp_nxt;
		end
	end

	assign data_valid_slot = data_valid_slot_r;
	assign row_start = rstart_r;
	assign sample_pulse = smp_r;

	// ==========================================================
	// row index inside the frame
	// the index restarts with each frame of a burst, so the odd/even choice
	// follows the rows of the array and not the running total of the burst
	logic frame_end;

	assign frame_end = row_done &&
		(row_cnt_r + 16'h0001 >= rows_total);

	always_comb begin
		row_cnt_nxt = row_cnt_r;
		if (!frame_active || frame_end) begin
			row_cnt_nxt = 16'h0000;
		end else if (row_done) begin
			row_cnt_nxt = row_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			row_cnt_r <= 16'h0000;
		end else begin
			row_cnt_r <= row_cnt_nxt;
		end
	end

	// ==========================================================
	// exposure selection per row; rows count from one, so index 0 is odd
	// row_exposure and odd_row are registered together from the same row
	// index, so both describe the row that is being read
	logic odd_r;
	logic [23:0] rexp_r;
	logic odd_nxt;
	logic [23:0] rexp_nxt;

	always_comb begin
		odd_nxt = ~row_cnt_nxt[0];
		if (cfg.dual_mode) begin
			rexp_nxt = odd_nxt ? v_exp_one : exposure_time_group_two;
		end else begin
			rexp_nxt = v_exp_one;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			odd_r <= 1'b1;
			rexp_r <= `SSTR_RST_EXP_ONE;
		end else begin
			odd_r <= odd_nxt;
			rexp_r <= rexp_nxt;
		end
	end

	assign odd_row = odd_r;
	assign row_exposure = rexp_r;

	// ==========================================================
	// frame burst sequencing
	// the burst is timed with the group one exposure only; group two
	// reaches the array through row_exposure in dual mode only, and in external mode the
	// pin decides the length instead
	sstr_frame_seq u_seq (
		.clk(clk),
		.rst_b(rst_b),
		.frame_req(frame_req),
		.ext_mode(cfg.ext_mode),
		.ext_exposure(ext_exposure),
		.frames(v_frames),
		.exp_len(v_exp_one),
		.row_done(row_done),
		.rows_per_frame(rows_total),
		.state(seq_state),
		.frame_active(frame_active),
		.frames_left()
	);
endmodule // sstr_timing_regs

// ===== sstr_timing_regs_checker.sv
// concurrent checks on the ports of the sequencer timing bank
`timescale 1ns/1ps
`include "sstr_cfg.svh"

module sstr_timing_regs_checker #(
	parameter int ROWS_PER_FRAME = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [6:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	input wire logic frame_req,
	input wire logic ext_exposure,
	input wire sstr_pkg::sstr_cfg_t cfg,
	input wire logic frame_active,
	input wire logic data_valid_slot,
	input wire logic row_start,
	input wire logic sample_pulse,
	input wire logic odd_row,
	input wire logic [23:0] row_exposure,
	input wire logic [11:0] train_word,
	input wire logic [4:0] lane_mux,
	input wire logic [3:0] lane_shutdown
);
	// ==========================================================
	// helper: length of the running sampling pulse
	logic [8:0] smp_cnt_r;
	logic [8:0] smp_cnt_nxt;
	always_comb begin
		smp_cnt_nxt = sample_pulse ? smp_cnt_r + 9'h001 : 9'h000;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) smp_cnt_r <= 9'h000;
		else smp_cnt_r <= smp_cnt_nxt;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// register port
	a_unmapped_reads_zero: assert property (cfg_rd && cfg_addr inside
		{7'h3f, 7'h40, [7'h42:7'h7f]} |=> cfg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_exp_one_low: assert property (cfg_wr && cfg_addr == `SSTR_ADDR_EXP_ONE
		|=> cfg.exp_one[7:0] == $past(cfg_wdata)) else $error("exp one low");
	a_exp_two_high: assert property (cfg_wr &&
		cfg_addr == `SSTR_ADDR_EXP_TWO + 7'h02
		|=> cfg.exp_two[23:16] == $past(cfg_wdata)) else $error("exp two high");
	a_slope_write: assert property (cfg_wr && cfg_addr == `SSTR_ADDR_SLOPES
		|=> cfg.slopes == $past(cfg_wdata[1:0])) else $error("slopes");
	a_knee_one_mid: assert property (cfg_wr &&
		cfg_addr == `SSTR_ADDR_KNEE_ONE + 7'h01
		|=> cfg.knee_one[15:8] == $past(cfg_wdata)) else $error("knee one");
	a_knee_two_top: assert property (cfg_wr &&
		cfg_addr == `SSTR_ADDR_KNEE_TWO + 7'h02
		|=> cfg.knee_two[23:16] == $past(cfg_wdata)) else $error("knee two");
	a_blank_write: assert property (cfg_wr && cfg_addr == `SSTR_ADDR_BLANK
		|=> cfg.blank_rows == $past(cfg_wdata)) else $error("blank rows");
	a_lane_outputs: assert property (train_word == cfg.train_word &&
		lane_mux == cfg.lane_mux && lane_shutdown == cfg.lane_shutdown)
		else $error("lane outputs differ from fields");
	a_reset_defaults: assert property ($rose(rst_b) |->
		cfg.exp_one == `SSTR_RST_EXP_ONE && cfg.frames == `SSTR_RST_FRAMES &&
		cfg.slot_cycles == `SSTR_RST_SLOT) else $error("defaults after reset");

	// ==========================================================
	// sequencer
	a_req_starts: assert property (frame_req && !frame_active &&
		!cfg.ext_mode && cfg.frames != 16'h0000 |=> frame_active)
		else $error("request did not start a frame");
	a_zero_frames_idle: assert property (!cfg.ext_mode &&
		cfg.frames == 16'h0000 && !frame_active |=> !frame_active)
		else $error("frame with zero count");
	a_ext_waits_pin: assert property (cfg.ext_mode && !ext_exposure &&
		!frame_active |=> !frame_active) else $error("ext mode ran alone");
	a_sample_length: assert property ($fell(sample_pulse) |->
		smp_cnt_r == {1'b0, cfg.sample_len}) else $error("sample length");
	a_row_exposure: assert property (row_start |-> ##1 row_exposure ==
		((cfg.dual_mode && !odd_row) ? cfg.exp_two : cfg.exp_one))
		else $error("row exposure");

	c_frame: cover property ($rose(frame_active));
	c_sample: cover property ($fell(sample_pulse));
	c_ext_frame: cover property (cfg.ext_mode && $rose(frame_active));
endmodule // sstr_timing_regs_checker

// ===== sstr_host.sv
// host controller model driving the configuration port
`timescale 1ns/1ps

module sstr_host (
	input wire logic clk,
	input wire logic [7:0] cfg_rdata,
	output sstr_pkg::sstr_req_t req
);
	initial req = '0;

	// released bus shows inverted lines, never the last value
	task automatic put(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic get(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
		@(negedge clk);
		d = cfg_rdata;
	endtask

	// low byte first, all bytes before any frame request
	task automatic put_field(input logic [6:0] a, input logic [23:0] v,
		input int n);
		for (int i = 0; i < n; i++) put(a + 7'(i), v[8*i +: 8]);
	endtask
endmodule // sstr_host

// ===== sstr_timing_regs_tb.sv
// self-checking bench for the sequencer timing bank
`timescale 1ns/1ps
`include "sstr_cfg.svh"

module sstr_timing_regs_tb;
	localparam int ROWS = 2;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic frame_req = 1'b0;
	logic ext_exposure = 1'b0;
	logic [7:0] cfg_rdata;
	logic [7:0] rd;
	sstr_pkg::sstr_req_t req;
	sstr_pkg::sstr_cfg_t cfg;
	logic frame_active;
	logic data_valid_slot;
	logic row_start;
	logic sample_pulse;
	logic odd_row;
	logic [23:0] row_exposure;
	logic [11:0] train_word;
	logic [4:0] lane_mux;
	logic [3:0] lane_shutdown;
	int fails = 0;
	int compares = 0;
	int mdl[128];
	int msk[128];
	int addrs[$];
	int unsigned seed = 38;
	int nr, ns, nd, nf, nx;

	always #25 clk = ~clk;

	sstr_timing_regs #(.ROWS_PER_FRAME(ROWS)) u_sstr_timing_regs (
		.clk(clk), .rst_b(rst_b), .cfg_wr(req.wr), .cfg_rd(req.rd),
		.cfg_addr(req.addr), .cfg_wdata(req.wdata), .cfg_rdata(cfg_rdata),
		.frame_req(frame_req), .ext_exposure(ext_exposure), .cfg(cfg),
		.frame_active(frame_active), .data_valid_slot(data_valid_slot),
		.row_start(row_start), .sample_pulse(sample_pulse), .odd_row(odd_row),
		.row_exposure(row_exposure), .train_word(train_word),
		.lane_mux(lane_mux), .lane_shutdown(lane_shutdown));
	sstr_host u_sstr_host (.clk(clk), .cfg_rdata(cfg_rdata), .req(req));

	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask

	// model bytes with the bits above each field's width masked off
	task automatic def(input int a, input int w, input int r);
		for (int i = 0; i < (w + 7) / 8; i++) begin
			msk[a+i] = (w - 8*i >= 8) ? 255 : (1 << (w - 8*i)) - 1;
			mdl[a+i] = (r >> 8*i) & msk[a+i];
			addrs.push_back(a + i);
		end
	endtask

	task automatic pulse_req();
		@(posedge clk) frame_req <= 1'b1;
		@(posedge clk) frame_req <= 1'b0;
	endtask

	task automatic measure();
		int n;
		nr = 0; ns = 0; nd = 0; nf = -1; nx = 0; n = 0;
		while (frame_active !== 1'b1 && n < 100) begin
			@(negedge clk); n++;
		end
		n = 0;
		while (frame_active === 1'b1 && n < 5000) begin
			if (row_start === 1'b1 && nf < 0) nf = n;
			nr += (row_start === 1'b1);
			ns += (sample_pulse === 1'b1);
			nd += (data_valid_slot === 1'b1);
			nx += (row_start === 1'b1 && odd_row === 1'b0 &&
				row_exposure === 24'h000014);
			@(negedge clk); n++;
		end
		// the valid flag trails the readout state by one cycle
		nd += (data_valid_slot === 1'b1);
	endtask

	task automatic conclude();
		if (fails == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end

	initial begin
		def('h28, 8, 4);
		def('h29, 24, 5056);
		def('h2c, 24, 0);
		def('h2f, 2, 1);
		def('h30, 24, 0);
		def('h33, 24, 0);
		def('h36, 16, 1);
		def('h38, 12, 85);
		def('h3a, 8, 1);
		def('h3b, 5, 1);
		def('h3c, 4, 7);
		def('h3d, 8, 112);
		def('h3e, 7, 2);
		def('h41, 8, 96);
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		// ==========================================================
		// defaults, then random bytes read back masked
		foreach (addrs[i]) begin
			u_sstr_host.get(7'(addrs[i]), rd);
			chk(rd, mdl[addrs[i]]);
		end
		foreach (addrs[i]) begin
			rd = 8'(xs());
			u_sstr_host.put(7'(addrs[i]), rd);
			mdl[addrs[i]] = rd & msk[addrs[i]];
		end
		u_sstr_host.put(7'h40, 8'(xs()));
		u_sstr_host.get(7'h40, rd);
		chk(rd, 0);
		foreach (addrs[i]) begin
			u_sstr_host.get(7'(addrs[i]), rd);
			chk(rd, mdl[addrs[i]]);
		end
		chk(cfg.exp_one, mdl['h2b] << 16 | mdl['h2a] << 8 | mdl['h29]);
		chk(train_word, mdl['h39] << 8 | mdl['h38]);
		chk(lane_mux, mdl['h3b]);
		chk(lane_shutdown, mdl['h3c]);
		// ==========================================================
		// short frames in dual mode: 2 frames of ROWS + 1 blank rows
		u_sstr_host.put_field(`SSTR_ADDR_EXP_ONE, 24'h00000c, 3);
		u_sstr_host.put_field(`SSTR_ADDR_EXP_TWO, 24'h000014, 3);
		u_sstr_host.put_field(`SSTR_ADDR_FRAMES, 24'h000002, 2);
		u_sstr_host.put(`SSTR_ADDR_BLANK, 8'h01);
		u_sstr_host.put(`SSTR_ADDR_SLOT, 8'h04);
		u_sstr_host.put(`SSTR_ADDR_ROW, 8'h02);
		u_sstr_host.put(`SSTR_ADDR_SAMPLE, 8'h03);
		u_sstr_host.put(`SSTR_ADDR_MODE, 8'h02);
		pulse_req();
		measure();
		chk(nr, 2 * (ROWS + 1));
		chk(ns, nr * 3);
		chk(nd, nr * 4 * 2);
		chk(nf >= 12 && nf <= 15, 1);
		chk(nx, 2 * ((ROWS + 1) / 2));
		// ==========================================================
		// zero frame count refuses the request
		u_sstr_host.put_field(`SSTR_ADDR_FRAMES, 24'h000000, 2);
		pulse_req();
		repeat (3) @(negedge clk);
		chk(frame_active, 0);
		// ==========================================================
		// external mode: request ignored, pin starts one frame
		u_sstr_host.put_field(`SSTR_ADDR_FRAMES, 24'h000002, 2);
		u_sstr_host.put(`SSTR_ADDR_MODE, 8'h01);
		pulse_req();
		repeat (3) @(negedge clk);
		chk(frame_active, 0);
		@(posedge clk) ext_exposure <= 1'b1;
		repeat (20) @(posedge clk);
		ext_exposure <= 1'b0;
		measure();
		chk(nr, ROWS + 1);
		conclude();
	end
endmodule // sstr_timing_regs_tb

bind sstr_timing_regs sstr_timing_regs_checker #(
	.ROWS_PER_FRAME(ROWS_PER_FRAME)
) u_chk (
	.clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.frame_req(frame_req), .ext_exposure(ext_exposure), .cfg(cfg),
	.frame_active(frame_active), .data_valid_slot(data_valid_slot),
	.row_start(row_start), .sample_pulse(sample_pulse), .odd_row(odd_row),
	.row_exposure(row_exposure), .train_word(train_word),
	.lane_mux(lane_mux), .lane_shutdown(lane_shutdown));
